/* File: rtl/ccr_defines.vh */
`ifndef CCR_DEFINES_VH
`define CCR_DEFINES_VH

// apb byte offsets, current-time set (read only)
`define CCR_OFF_CUR_YEAR 8'h00
`define CCR_OFF_CUR_MONTH 8'h04
`define CCR_OFF_CUR_DAY 8'h08
`define CCR_OFF_CUR_WEEKDAY 8'h0C
`define CCR_OFF_CUR_HOUR 8'h10
`define CCR_OFF_CUR_MINUTE 8'h14
`define CCR_OFF_CUR_SECOND 8'h18
// new-value set (write only)
`define CCR_OFF_NEW_YEAR 8'h1C
`define CCR_OFF_NEW_MONTH 8'h20
`define CCR_OFF_NEW_DAY 8'h24
`define CCR_OFF_NEW_WEEKDAY 8'h28
`define CCR_OFF_NEW_HOUR 8'h2C
`define CCR_OFF_NEW_MINUTE 8'h30
`define CCR_OFF_NEW_SECOND 8'h34
// control, configuration and error registers
`define CCR_OFF_FLAGS 8'h38
`define CCR_OFF_CONFIG 8'h3C
`define CCR_OFF_ERROR 8'h40

// flags register bit positions
`define CCR_BIT_CAL_WRITE 0
`define CCR_BIT_TIME_WRITE 1
`define CCR_BIT_CAL_TIME_WRITE 2
`define CCR_BIT_SEC_ROUND 3
`define CCR_FLAGS_W 4
// config register bit position
`define CCR_BIT_CLOCK_USE 0

// restart values after backup loss
`define CCR_RST_YEAR 7'h00
`define CCR_RST_MONTH 4'h1
`define CCR_RST_DAY 5'h01
`define CCR_RST_WEEKDAY 3'h0
`define CCR_RST_TIME 6'h00

// field limits and seconds round-up threshold
`define CCR_MAX_YEAR 7'h63
`define CCR_MAX_MONTH 4'hC
`define CCR_MAX_WEEKDAY 3'h6
`define CCR_MAX_HOUR 5'h17
`define CCR_MAX_MINSEC 6'h3B
`define CCR_ROUND_UP_SEC 6'h1E

// clock-missing error code
`define CCR_ERR_NO_CLOCK 16'h0400

// timing: refresh interval and core clock
`define CCR_REFRESH_MS 500
`define CCR_CLK_KHZ 250000
`define CCR_REFRESH_CYCLES (`CCR_REFRESH_MS * `CCR_CLK_KHZ)

`endif

/* File: rtl/ccr_divider.v */
module ccr_divider #(
  parameter DIV = 125000000
) (
  input wire i_core_clk,
  input wire i_nrst,
  input wire i_clear,
  output reg o_tick
);
  localparam W = $clog2(DIV + 1);
  localparam [31:0] LAST_FULL = DIV - 1;
  localparam [W-1:0] LAST = LAST_FULL[W-1:0];
  localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

  reg [W-1:0] count;

  // restart keeps a fresh load from ticking early
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      count <= {W{1'b0}};
      o_tick <= 1'b0;
    end else if (i_clear) begin
      count <= {W{1'b0}};
      o_tick <= 1'b0;
    end else if (count == LAST) begin
      count <= {W{1'b0}};
      o_tick <= 1'b1;
    end else begin
      count <= count + ONE;
      o_tick <= 1'b0;
    end
  end
endmodule

/* File: rtl/ccr_regs.v */
`include "ccr_defines.vh"

// Operation
// - current year 0-99, month 1-12, day 1-31, weekday 0-6, hh/mm/ss binary
// - current set read only; refreshed at larger of half second and one scan
// - seven write-only new-value registers, never updated by the clock
// - weekday 0 is Sunday through 6 Saturday, in both sets
// - calendar write copies new year, month, day, weekday into the clock
// - time write copies new hour, minute, second into the clock
// - combined write copies all seven new values together
// - adjust: seconds 0-29 go to 0; 30-59 go to 0 and minute increments
// - backup loss restarts clock at 00/01/01 0:00:00
// - new-value registers are not cleared at start
// - clock use configured without clock present gives error code 400h
module ccr_regs #(
  parameter REFRESH_CYCLES = `CCR_REFRESH_CYCLES
) (
  input wire i_core_clk,
  input wire i_nrst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output reg o_pslverr,
  input wire i_scan_end,
  input wire i_clock_present,
  input wire i_backup_lost,
  output reg o_clock_error
);
  ////////////////////////////////////////////////////////////////////////////
  // clock fields
  reg [6:0] yr;
  reg [3:0] mo;
  reg [4:0] dy;
  reg [2:0] wd;
  reg [4:0] hr;
  reg [5:0] mi;
  reg [5:0] se;
  // current-time snapshot seen by software
  reg [6:0] cur_yr;
  reg [3:0] cur_mo;
  reg [4:0] cur_dy;
  reg [2:0] cur_wd;
  reg [4:0] cur_hr;
  reg [5:0] cur_mi;
  reg [5:0] cur_se;
  // new-value set, no reset on purpose
  reg [15:0] new_year;
  reg [15:0] new_month;
  reg [15:0] new_day;
  reg [15:0] new_weekday;
  reg [15:0] new_hour;
  reg [15:0] new_minute;
  reg [15:0] new_second;
  // control
  reg [`CCR_FLAGS_W-1:0] flags;
  reg [`CCR_FLAGS_W-1:0] flags_prev;
  reg clock_use;
  reg [15:0] general_error_code;
  reg refresh_due;
  reg sec_phase;

  wire half_tick;
  wire setup = i_psel & ~i_penable;
  wire wr = i_psel & i_penable & i_pwrite;
  wire clock_ok = ~(clock_use & ~i_clock_present);
  wire [`CCR_FLAGS_W-1:0] flag_rise = flags & ~flags_prev;
  wire cal_load = clock_ok & (flag_rise[`CCR_BIT_CAL_WRITE] |
                  flag_rise[`CCR_BIT_CAL_TIME_WRITE]);
  wire time_load = clock_ok & (flag_rise[`CCR_BIT_TIME_WRITE] |
                   flag_rise[`CCR_BIT_CAL_TIME_WRITE]);
  wire round_req = clock_ok & flag_rise[`CCR_BIT_SEC_ROUND];
  wire sec_tick = half_tick & sec_phase;
  wire restart = i_backup_lost | time_load | round_req;

  ////////////////////////////////////////////////////////////////////////////
  // half-second timebase; the second tick is every other pulse
  ccr_divider #(
    .DIV(REFRESH_CYCLES)
  ) u_half (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_clear(restart),
    .o_tick(half_tick)
  );

  always @(posedge i_core_clk) begin
    if (!i_nrst)
      sec_phase <= 1'b0;
    else if (restart)
      sec_phase <= 1'b0;
    else if (half_tick)
      sec_phase <= ~sec_phase;
  end

  ////////////////////////////////////////////////////////////////////////////
  // calendar arithmetic, two-digit year so every fourth year is leap
  function [4:0] days_in;
    input [3:0] m;
    input [6:0] y;
    begin
      case (m)
        4'h2: days_in = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
        4'h4, 4'h6, 4'h9, 4'hB: days_in = 5'h1E;
        default: days_in = 5'h1F;
      endcase
    end
  endfunction

  reg [6:0] next_yr;
  reg [3:0] next_mo;
  reg [4:0] next_dy;
  reg [2:0] next_wd;
  reg [4:0] next_hr;
  reg [5:0] next_mi;
  reg [5:0] next_se;
  reg c_min;
  reg c_hr;
  reg c_day;
  reg c_mo;
  reg c_yr;

  always @* begin
    next_yr = yr;
    next_mo = mo;
    next_dy = dy;
    next_wd = wd;
    next_hr = hr;
    next_mi = mi;
    next_se = se;
    c_min = 1'b0;
    c_hr = 1'b0;
    c_day = 1'b0;
    c_mo = 1'b0;
    c_yr = 1'b0;
    if (round_req) begin
      next_se = `CCR_RST_TIME;
      c_min = (se >= `CCR_ROUND_UP_SEC);
    end else if (sec_tick) begin
      if (se >= `CCR_MAX_MINSEC) begin
        next_se = `CCR_RST_TIME;
        c_min = 1'b1;
      end else begin
        next_se = se + 6'h01;
      end
    end
    if (c_min) begin
      if (mi >= `CCR_MAX_MINSEC) begin
        next_mi = `CCR_RST_TIME;
        c_hr = 1'b1;
      end else begin
        next_mi = mi + 6'h01;
      end
    end
    if (c_hr) begin
      if (hr >= `CCR_MAX_HOUR) begin
        next_hr = 5'h00;
        c_day = 1'b1;
      end else begin
        next_hr = hr + 5'h01;
      end
    end
    if (c_day) begin
      next_wd = (wd >= `CCR_MAX_WEEKDAY) ? `CCR_RST_WEEKDAY : wd + 3'h1;
      if (dy >= days_in(mo, yr)) begin
        next_dy = `CCR_RST_DAY;
        c_mo = 1'b1;
      end else begin
        next_dy = dy + 5'h01;
      end
    end
    if (c_mo) begin
      if (mo >= `CCR_MAX_MONTH) begin
        next_mo = `CCR_RST_MONTH;
        c_yr = 1'b1;
      end else begin
        next_mo = mo + 4'h1;
      end
    end
    if (c_yr)
      next_yr = (yr >= `CCR_MAX_YEAR) ? `CCR_RST_YEAR : yr + 7'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock state: backup loss, then loads, then round or tick
  always @(posedge i_core_clk) begin
    if (!i_nrst || i_backup_lost) begin
      yr <= `CCR_RST_YEAR;
      mo <= `CCR_RST_MONTH;
      dy <= `CCR_RST_DAY;
      wd <= `CCR_RST_WEEKDAY;
      hr <= 5'h00;
      mi <= `CCR_RST_TIME;
      se <= `CCR_RST_TIME;
    end else if (cal_load || time_load) begin
      // a load beats a same-cycle tick; unloaded part keeps its value
      if (cal_load) begin
        yr <= new_year[6:0];
        mo <= new_month[3:0];
        dy <= new_day[4:0];
        wd <= new_weekday[2:0];
      end
      if (time_load) begin
        hr <= new_hour[4:0];
        mi <= new_minute[5:0];
        se <= new_second[5:0];
      end
    end else begin
      yr <= next_yr;
      mo <= next_mo;
      dy <= next_dy;
      wd <= next_wd;
      hr <= next_hr;
      mi <= next_mi;
      se <= next_se;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // snapshot refresh: waits for both half second and scan end
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      refresh_due <= 1'b0;
      cur_yr <= `CCR_RST_YEAR;
      cur_mo <= `CCR_RST_MONTH;
      cur_dy <= `CCR_RST_DAY;
      cur_wd <= `CCR_RST_WEEKDAY;
      cur_hr <= 5'h00;
      cur_mi <= `CCR_RST_TIME;
      cur_se <= `CCR_RST_TIME;
    end else begin
      if (half_tick)
        refresh_due <= 1'b1;
      else if (i_scan_end && refresh_due)
        refresh_due <= 1'b0;
      if (i_scan_end && refresh_due) begin
        cur_yr <= yr;
        cur_mo <= mo;
        cur_dy <= dy;
        cur_wd <= wd;
        cur_hr <= hr;
        cur_mi <= mi;
        cur_se <= se;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // new-value set, write only; content undefined until written
  always @(posedge i_core_clk) begin
    if (wr) begin
      case (i_paddr)
        `CCR_OFF_NEW_YEAR: new_year <= i_pwdata[15:0];
        `CCR_OFF_NEW_MONTH: new_month <= i_pwdata[15:0];
        `CCR_OFF_NEW_DAY: new_day <= i_pwdata[15:0];
        `CCR_OFF_NEW_WEEKDAY: new_weekday <= i_pwdata[15:0];
        `CCR_OFF_NEW_HOUR: new_hour <= i_pwdata[15:0];
        `CCR_OFF_NEW_MINUTE: new_minute <= i_pwdata[15:0];
        `CCR_OFF_NEW_SECOND: new_second <= i_pwdata[15:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags, config and error code
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      flags <= {`CCR_FLAGS_W{1'b0}};
      flags_prev <= {`CCR_FLAGS_W{1'b0}};
      clock_use <= 1'b0;
      general_error_code <= 16'h0000;
      o_clock_error <= 1'b0;
    end else begin
      // held flag does not repeat the action
      flags_prev <= flags;
      if (wr && i_paddr == `CCR_OFF_FLAGS)
        flags <= i_pwdata[`CCR_FLAGS_W-1:0];
      if (wr && i_paddr == `CCR_OFF_CONFIG)
        clock_use <= i_pwdata[`CCR_BIT_CLOCK_USE];
      // set wins over a same-cycle software clear
      if (!clock_ok)
        general_error_code <= `CCR_ERR_NO_CLOCK;
      else if (wr && i_paddr == `CCR_OFF_ERROR)
        general_error_code <= 16'h0000;
      o_clock_error <= ~clock_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read side; data captured in setup so pready can stay high
  reg [31:0] rd_mux;
  reg rd_hit;

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (i_paddr)
      `CCR_OFF_CUR_YEAR: rd_mux = {25'h000_0000, cur_yr};
      `CCR_OFF_CUR_MONTH: rd_mux = {28'h000_0000, cur_mo};
      `CCR_OFF_CUR_DAY: rd_mux = {27'h000_0000, cur_dy};
      `CCR_OFF_CUR_WEEKDAY: rd_mux = {29'h000_0000, cur_wd};
      `CCR_OFF_CUR_HOUR: rd_mux = {27'h000_0000, cur_hr};
      `CCR_OFF_CUR_MINUTE: rd_mux = {26'h000_0000, cur_mi};
      `CCR_OFF_CUR_SECOND: rd_mux = {26'h000_0000, cur_se};
      `CCR_OFF_NEW_YEAR, `CCR_OFF_NEW_MONTH, `CCR_OFF_NEW_DAY,
      `CCR_OFF_NEW_WEEKDAY, `CCR_OFF_NEW_HOUR, `CCR_OFF_NEW_MINUTE,
      `CCR_OFF_NEW_SECOND: rd_mux = 32'h0000_0000;
      `CCR_OFF_FLAGS: rd_mux = {28'h000_0000, flags};
      `CCR_OFF_CONFIG: rd_mux = {31'h0000_0000, clock_use};
      `CCR_OFF_ERROR: rd_mux = {16'h0000, general_error_code};
      default: rd_hit = 1'b0;
    endcase
  end

  assign o_pready = 1'b1;

  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      // writes to the current set are silently dropped
      o_prdata <= i_pwrite ? 32'h0000_0000 : rd_mux;
      o_pslverr <= ~rd_hit;
    end else if (!i_psel) begin
      o_pslverr <= 1'b0;
    end
  end
endmodule

/* File: verif/ccr_regs_assertions.sv */
module ccr_regs_check #(
  parameter REFRESH_CYCLES = 10
) (
  input wire i_core_clk,
  input wire i_nrst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire o_pready,
  input wire [31:0] o_prdata,
  input wire o_pslverr,
  input wire i_scan_end,
  input wire i_clock_present,
  input wire i_backup_lost,
  input wire o_clock_error
);
  logic cfg_q;
  wire rd_setup = i_psel && !i_penable && !i_pwrite;
  // mirror of the clock-use bit, stored at the same access edge as in the block
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst)
      cfg_q <= 1'b0;
    else if (i_psel && i_penable && i_pwrite && i_paddr == 8'h3C)
      cfg_q <= i_pwdata[0];
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////////////////////////////////////
  AST_READY: assert property (o_pready) else $error("pready low");
  AST_CLK_ERR_SET: assert property (cfg_q && !i_clock_present |=> o_clock_error)
    else $error("clock error not raised");
  AST_CLK_ERR_CLR: assert property (!(cfg_q && !i_clock_present) |=> !o_clock_error)
    else $error("clock error without cause");
  AST_ERR_CODE: assert property (rd_setup && i_paddr == 8'h40 && o_clock_error &&
    $past(o_clock_error) |=> o_prdata == 32'h0000_0400) else $error("error code wrong");
  AST_WO_ZERO: assert property (rd_setup && i_paddr >= 8'h1C && i_paddr <= 8'h34
    |=> o_prdata == 32'h0000_0000) else $error("write-only read not zero");
  AST_MAPPED: assert property (rd_setup && i_paddr <= 8'h40 && i_paddr[1:0] == 2'b00
    |=> !o_pslverr) else $error("slverr on mapped address");
  AST_UNMAPPED: assert property (rd_setup && (i_paddr > 8'h40 || i_paddr[1:0] != 2'b00)
    |=> o_pslverr) else $error("slverr missing on unmapped address");
  AST_SLVERR_IDLE: assert property (!i_psel |=> !o_pslverr)
    else $error("slverr held while idle");
  AST_YEAR: assert property (rd_setup && i_paddr == 8'h00 |=> o_prdata < 32'h0000_0064)
    else $error("year out of range");
  AST_MONTH: assert property (rd_setup && i_paddr == 8'h04
    |=> o_prdata inside {[32'h0000_0001:32'h0000_000C]}) else $error("month out of range");
  AST_DAY: assert property (rd_setup && i_paddr == 8'h08
    |=> o_prdata inside {[32'h0000_0001:32'h0000_001F]}) else $error("day out of range");
  AST_WEEKDAY: assert property (rd_setup && i_paddr == 8'h0C |=> o_prdata < 32'h0000_0007)
    else $error("weekday out of range");
  AST_HOUR: assert property (rd_setup && i_paddr == 8'h10 |=> o_prdata < 32'h0000_0018)
    else $error("hour out of range");
  AST_MINSEC: assert property (rd_setup && (i_paddr == 8'h14 || i_paddr == 8'h18)
    |=> o_prdata < 32'h0000_003C) else $error("minute or second out of range");
endmodule

bind ccr_regs ccr_regs_check #(.REFRESH_CYCLES(REFRESH_CYCLES)) chk_u (.i_core_clk, .i_nrst,
  .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr,
  .i_scan_end, .i_clock_present, .i_backup_lost, .o_clock_error);

/* File: verif/ccr_cart_model.sv */
module ccr_cart_model (
  input wire i_clk,
  input wire i_fitted,
  input wire i_drain,
  output logic o_present,
  output logic o_lost,
  output logic o_scan_end
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt = 2'b00;
  // short scan keeps the refresh wait bounded by the half-second period
  // scan end is unknown until the first edge, well inside the reset span
  always @(posedge i_clk) begin
    cnt <= cnt + 2'b01;
    o_scan_end <= (cnt == 2'b11);
  end
  assign o_present = i_fitted;
  assign o_lost = i_drain;
endmodule

/* File: verif/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, fit = 1, lose = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  wire pready, pslverr, clk_err, scan, present, lost;
  wire [31:0] rdata;
  logic [32:0] q[$];
  logic [32:0] e;
  logic [15:0] nv [7];
  int fails = 0, n_tests = 0;
  always #2 clk = ~clk;
  ccr_regs #(.REFRESH_CYCLES(200)) dut_u (.i_core_clk(clk), .i_nrst(nrst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_pready(pready),
    .o_prdata(rdata), .o_pslverr(pslverr), .i_scan_end(scan), .i_clock_present(present),
    .i_backup_lost(lost), .o_clock_error(clk_err));
  ccr_cart_model cart_u (.i_clk(clk), .i_fitted(fit), .i_drain(lose), .o_present(present),
    .o_lost(lost), .o_scan_end(scan));
  ////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
    @(posedge clk);
    psel <= 1; pwr <= w; addr <= a; wd <= d; pen <= 0;
    if (!w) q.push_back(x);
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 0; pen <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0_0000_0000);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0000_0000, {1'b0, d});
  endtask
  // reads the current fields selected in m
  task chk7(input logic [6:0] m, input logic [15:0] x [7]);
    for (int k = 0; k < 7; k++) if (m[k]) rd(8'(k * 4), {16'h0000, x[k]});
  endtask
  task wrnew(input logic [15:0] x [7]);
    for (int k = 0; k < 7; k++) wr(8'(8'h1C + k * 4), {16'h0000, x[k]});
  endtask
  // fixed wait of 260 cycles: more than one half-second period plus a scan, well short of a seconds tick
  task flag(input logic [3:0] f);
    wr(8'h38, {28'h000_0000, f});
    repeat (260) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1 && !pwr) begin
      e = q.pop_front();
      n_tests++;
      if ({pslverr, rdata} !== e) begin
        fails++;
        $display("ERROR t=%0t exp=%h got=%h", $time, e, {pslverr, rdata});
      end
    end
  end
  initial begin
    #100us;
    fails++;
    complete_run;
  end
  initial begin
    void'($urandom(72));
    repeat (6) @(posedge clk);
    nrst <= 1;
    chk7(7'h7F, '{16'h0, 16'h1, 16'h1, 16'h0, 16'h0, 16'h0, 16'h0});
    wrnew('{16'h63, 16'hC, 16'h1F, 16'h6, 16'h17, 16'h3B, 16'h1D});
    rd(8'h1C, 32'h0000_0000);
    wr(8'h00, 32'h0000_0005);
    rd(8'h00, 32'h0000_0000);
    apb(1'b0, 8'h80, 32'h0000_0000, 33'h1_0000_0000);
    flag(4'h2);
    chk7(7'h7F, '{16'h0, 16'h1, 16'h1, 16'h0, 16'h17, 16'h3B, 16'h1D});
    flag(4'h8);
    chk7(7'h70, '{16'h0, 16'h1, 16'h1, 16'h0, 16'h17, 16'h3B, 16'h0});
    wr(8'h30, 32'h0000_000A);
    wr(8'h34, 32'h0000_001E);
    flag(4'h2);
    flag(4'h8);
    chk7(7'h70, '{16'h0, 16'h1, 16'h1, 16'h0, 16'h17, 16'hB, 16'h0});
    flag(4'h1);
    chk7(7'h1F, '{16'h63, 16'hC, 16'h1F, 16'h6, 16'h17, 16'h0, 16'h0});
    // day kept at 28 or below so every month takes it
    nv = '{16'($urandom % 100), 16'(1 + $urandom % 12), 16'(1 + $urandom % 28),
      16'($urandom % 7), 16'($urandom % 24), 16'($urandom % 60), 16'($urandom % 60)};
    wrnew(nv);
    flag(4'h4);
    chk7(7'h7F, nv);
    wr(8'h1C, {16'h0000, nv[0] + 16'h1});
    flag(4'h4);
    chk7(7'h01, nv);
    @(posedge clk);
    lose <= 1;
    @(posedge clk);
    lose <= 0;
    // no refresh is pending here, so the current set must still be stale
    rd(8'h00, {16'h0000, nv[0]});
    repeat (260) @(posedge clk);
    chk7(7'h7F, '{16'h0, 16'h1, 16'h1, 16'h0, 16'h0, 16'h0, 16'h0});
    wr(8'h3C, 32'h0000_0001);
    fit <= 0;
    repeat (3) @(posedge clk);
    rd(8'h40, 32'h0000_0400);
    fit <= 1;
    wr(8'h3C, 32'h0000_0000);
    repeat (4) @(posedge clk);
    complete_run;
  end
endmodule
